// >>> inc/lcsr_pkg.sv
// Register map, field layout and carrier types of the logic clock and frame reference block.
// Function
// - Logic clock prescaler divides by 1, 2 or 4.
// - Post divider ratio 1 to 1023, 1 bypasses.
// - Odd post ratio above 1 gives unbalanced duty cycle.
// - Sync resets both logic clock divider phases.
// - One generator feeds main and logic channels.
// - Per-output software delay to paired clock.
// - Mode 0 runs the generator continuously.
// - Mode 0 output gated by pin or software.
// - Mode 1 emits a burst of 1 to 16.
// - Burst starts on pin or software rising edge.
// - Mode 2 reclocks and delays the request pin.
// - Each main output: 3-bit common mode, level.
package lcsr_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [11:0] LCSR_OFF_CTRL = 12'h000;
    localparam logic [11:0] LCSR_OFF_LDIV = 12'h004;
    localparam logic [11:0] LCSR_OFF_FCFG = 12'h008;
    localparam logic [11:0] LCSR_OFF_FDLY = 12'h00C;
    localparam logic [11:0] LCSR_OFF_FOUT = 12'h010;
    localparam logic [11:0] LCSR_OFF_STAT = 12'h014;
    // Control register field positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SWREQ_BIT = 2;
    localparam int CTRL_SYNC_BIT = 3;
    localparam int CTRL_PRE_LSB = 4;
    // Frame reference configuration field positions.
    localparam int FCFG_LEN_LSB = 4'h0;
    localparam int FCFG_PATH_LSB = 4;
    localparam int FCFG_PER_LSB = 8;
    // Per-channel field widths.
    localparam int DLY_W = 4;
    localparam int VCM_W = 3;
    // Reset values.
    localparam logic [9:0] RST_POST = 10'h001;
    localparam logic [7:0] RST_PER = 8'h10;
    // Shortest generator period in clock cycles.
    localparam logic [7:0] GEN_MIN_PER = 8'h02;
    // Delay path code that skips the delay taps.
    localparam logic [1:0] PATH_BYPASS = 2'h1;
    // Frame reference modes.
    typedef enum logic [1:0] {MODE_CONT, MODE_PULSER, MODE_REPEAT, MODE_RSVD} lcsr_mode_e;
    // Logic clock divider settings.
    typedef struct packed {
        logic [1:0] pre;
        logic [9:0] post;
    } lcsr_lcfg_s;
endpackage : lcsr_pkg

// >>> core/lcsr_lcdiv.sv
// Two-stage logic clock divider with synchronous phase reset.
`timescale 1ns/100ps
`default_nettype none
module lcsr_lcdiv
    import lcsr_pkg::*;
(
    input wire logic clk, // Block clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire lcsr_lcfg_s cfg, // Prescaler and post ratio.
    input wire logic sync, // Phase reset pulse.
    output logic lclk, // Divided logic clock level.
    output logic rise // Pulse after each rising edge.
);
    // All divider state.
    typedef struct packed {
        logic [1:0] pre_cnt;
        logic [9:0] post_cnt;
        logic lvl;
        logic rise;
    } lcsr_div_s;
    lcsr_div_s s_reg; // Registered state.
    lcsr_div_s s_next; // Next state.
    logic [1:0] pre_max; // Last prescaler count.
    logic [9:0] ratio; // Effective post ratio.

    // Next state: prescaler enables the post counter.
    always_comb begin
        pre_max = (cfg.pre == 2'h0) ? 2'h0 : ((cfg.pre == 2'h1) ? 2'h1 : 2'h3);
        // Ratio zero is taken as one so the stage never stalls.
        ratio = (cfg.post == 10'h000) ? 10'h001 : cfg.post;
        s_next = s_reg;
        if (sync) begin
            // Both stages restart at phase zero.
            s_next.pre_cnt = 2'h0;
            s_next.post_cnt = 10'h000;
        end else if (s_reg.pre_cnt >= pre_max) begin
            s_next.pre_cnt = 2'h0;
            s_next.post_cnt = (s_reg.post_cnt >= ratio - 10'h001) ? 10'h000 : s_reg.post_cnt + 10'h001;
        end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 2'h1;
        end
        if (ratio == 10'h001) begin
            // Bypass: the level follows the prescaler phase.
            s_next.lvl = s_next.pre_cnt <= (pre_max >> 1);
        end else begin
            // Odd ratios are high one count less than low.
            s_next.lvl = s_next.post_cnt < (ratio >> 1);
        end
        // Total ratio one cannot be shown as a level, so every cycle is a rise.
        s_next.rise = (s_next.lvl & ~s_reg.lvl) | (pre_max == 2'h0 && ratio == 10'h001);
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lclk = s_reg.lvl;
    assign rise = s_reg.rise;
endmodule : lcsr_lcdiv
`default_nettype wire

// >>> core/lcsr_delay.sv
// Tapped delay line for one frame reference output.
`timescale 1ns/100ps
`default_nettype none
module lcsr_delay #(
    parameter int DEPTH = 16 // Number of delay taps.
) (
    input wire logic clk, // Block clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic din, // Undelayed frame reference.
    input wire logic [$clog2(DEPTH)-1:0] sel, // Tap index.
    input wire logic bypass, // Skip the taps.
    output logic dout // Delayed frame reference.
);
    // Shift register and output flop.
    typedef struct packed {
        logic [DEPTH-1:0] sh;
        logic q;
    } lcsr_dly_s;
    lcsr_dly_s s_reg; // Registered state.
    lcsr_dly_s s_next; // Next state.

    // Shift every cycle and pick the selected tap.
    always_comb begin
        s_next.sh = {s_reg.sh[DEPTH-2:0], din};
        s_next.q = bypass ? din : s_reg.sh[sel];
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.q;
endmodule : lcsr_delay
`default_nettype wire

// >>> core/lcsr_top.sv
// Logic clock and frame reference block with its APB register slave.
`timescale 1ns/100ps
`default_nettype none
module lcsr_top
    import lcsr_pkg::*;
#(
    parameter int NCH = 4 // Main clock channels, at most 5.
) (
    input wire logic clk, // Block clock, 10 MHz.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic frame_ref_request_pins, // Request pin level.
    input wire logic sync_pin, // Synchronisation input.
    output logic logic_clock_output, // Divided logic clock.
    output logic [NCH-1:0] frame_ref_main_outputs, // Main outputs.
    output logic frame_ref_logic_output, // Logic channel output.
    output logic [VCM_W*NCH-1:0] frame_ref_out_common_mode, // Common mode codes.
    output logic [VCM_W*NCH-1:0] frame_ref_out_level // Level codes.
);
    // Tap count follows the delay field width.
    localparam int DDEPTH = 1 << DLY_W;
    // Width of the delay register.
    localparam int DW = DLY_W * (NCH + 1);
    // Width of the output setting register.
    localparam int OW = 2 * VCM_W * NCH;

    // All state of the block.
    typedef struct packed {
        lcsr_mode_e mode; // Frame reference mode.
        logic sw_req; // Software request bit.
        logic [1:0] pre; // Prescaler select.
        logic [9:0] post; // Post divider ratio.
        logic [3:0] len; // Burst length minus one.
        logic [1:0] path; // Delay path select.
        logic [7:0] per; // Generator period.
        logic [DW-1:0] dly; // Delay per output.
        logic [OW-1:0] ocfg; // Output settings.
        logic [31:0] rdata; // Read data.
        logic err; // Error answer.
        logic sync_p; // Software sync pulse.
        logic sync_q; // Previous sync pin.
        logic req_q; // Previous request pin.
        logic sw_q; // Previous request bit.
        logic [7:0] gcnt; // Generator phase.
        logic [4:0] left; // Periods left.
        logic active; // Burst running.
        logic rpt; // Reclocked request pin.
        logic src; // Undelayed reference.
        logic [NCH-1:0] mout; // Main outputs.
        logic lout; // Logic output.
    } lcsr_top_s;
    lcsr_top_s s_reg; // Registered state.
    lcsr_top_s s_next; // Next state.

    logic lclk; // Logic clock level.
    logic lclk_rise; // Logic clock rise pulse.
    logic [NCH:0] dly_out; // Delay line outputs.
    logic sync_ev; // Synchronisation event.
    logic req_rise; // Request pin rising.
    logic sw_rise; // Request bit rising.
    logic start; // Burst start.
    logic gate; // Continuous mode gate.
    logic wrap; // Generator period end.
    logic gen_lvl; // Generator level.
    logic [7:0] per_eff; // Usable period.
    lcsr_lcfg_s lcfg; // Divider settings.

    // Mapped register offsets.
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == LCSR_OFF_CTRL) || (a == LCSR_OFF_LDIV) || (a == LCSR_OFF_FCFG) ||
                  (a == LCSR_OFF_FDLY) || (a == LCSR_OFF_FOUT) || (a == LCSR_OFF_STAT);
    endfunction : addr_ok

    // Registers, generator, burst and mode select.
    always_comb begin
        s_next = s_reg;
        s_next.sync_p = 1'h0;
        // Read data and error are prepared in the setup phase.
        if (psel && !penable) begin
            s_next.err = ~addr_ok(paddr);
            case (paddr)
                LCSR_OFF_CTRL: begin
                    s_next.rdata = {26'h0, s_reg.pre, 1'h0, s_reg.sw_req, s_reg.mode};
                end
                LCSR_OFF_LDIV: begin
                    s_next.rdata = {22'h0, s_reg.post};
                end
                LCSR_OFF_FCFG: begin
                    s_next.rdata = {16'h0, s_reg.per, 2'h0, s_reg.path, s_reg.len};
                end
                LCSR_OFF_FDLY: begin
                    s_next.rdata = 32'(s_reg.dly);
                end
                LCSR_OFF_FOUT: begin
                    s_next.rdata = 32'(s_reg.ocfg);
                end
                LCSR_OFF_STAT: begin
                    s_next.rdata = {22'h0, s_reg.mode, s_reg.lout, s_reg.left, s_reg.active, lclk};
                end
                default: begin
                    // Unmapped addresses read as zero.
                    s_next.rdata = 32'h0;
                end
            endcase
        end
        // Writes take effect in the access phase.
        if (psel && penable && pwrite && addr_ok(paddr)) begin
            case (paddr)
                LCSR_OFF_CTRL: begin
                    s_next.mode = lcsr_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
                    s_next.sw_req = pwdata[CTRL_SWREQ_BIT];
                    s_next.pre = pwdata[CTRL_PRE_LSB +: 2];
                    // The sync bit is a command and reads back as zero.
                    s_next.sync_p = pwdata[CTRL_SYNC_BIT];
                end
                LCSR_OFF_LDIV: begin
                    s_next.post = pwdata[9:0];
                end
                LCSR_OFF_FCFG: begin
                    s_next.len = pwdata[FCFG_LEN_LSB +: 4];
                    s_next.path = pwdata[FCFG_PATH_LSB +: 2];
                    s_next.per = pwdata[FCFG_PER_LSB +: 8];
                end
                LCSR_OFF_FDLY: begin
                    s_next.dly = pwdata[DW-1:0];
                end
                LCSR_OFF_FOUT: begin
                    s_next.ocfg = pwdata[OW-1:0];
                end
                default: begin
                    // Status is read only.
                    s_next.err = s_reg.err;
                end
            endcase
        end

        // Edge detection on the request sources and the sync pin.
        s_next.req_q = frame_ref_request_pins;
        s_next.sw_q = s_reg.sw_req;
        s_next.sync_q = sync_pin;
        req_rise = frame_ref_request_pins & ~s_reg.req_q;
        // The bit edge comes from the bit and its previous value alone; the pins play no part.
        sw_rise = s_reg.sw_req & ~s_reg.sw_q;
        sync_ev = s_reg.sync_p | (sync_pin & ~s_reg.sync_q);
        start = (s_reg.mode == MODE_PULSER) & (req_rise | sw_rise);
        gate = frame_ref_request_pins | s_reg.sw_req;

        // Periods below two cannot form a high and a low half.
        per_eff = (s_reg.per < GEN_MIN_PER) ? GEN_MIN_PER : s_reg.per;
        wrap = s_reg.gcnt >= per_eff - 8'h01;
        // The generator free-runs; gating never touches its phase.
        s_next.gcnt = wrap ? 8'h00 : s_reg.gcnt + 8'h01;
        if (sync_ev) begin
            // Sync realigns the generator and aborts a burst.
            s_next.gcnt = 8'h00;
            s_next.active = 1'h0;
            s_next.left = 5'h00;
        end else if (start) begin
            // A burst begins at phase zero with its full count.
            s_next.gcnt = 8'h00;
            s_next.active = 1'h1;
            s_next.left = {1'h0, s_reg.len} + 5'h01;
        end else if (s_reg.active && wrap) begin
            // One period of the burst has passed.
            s_next.left = s_reg.left - 5'h01;
            s_next.active = s_reg.left > 5'h01;
        end
        gen_lvl = s_next.gcnt < (per_eff >> 1);

        // Repeater input is reclocked before use.
        s_next.rpt = frame_ref_request_pins;
        unique case (s_reg.mode)
            MODE_CONT: begin
                s_next.src = gen_lvl & gate;
            end
            MODE_PULSER: begin
                s_next.src = gen_lvl & s_next.active;
            end
            MODE_REPEAT: begin
                s_next.src = s_reg.rpt;
            end
            MODE_RSVD: begin
                s_next.src = 1'h0;
            end
        endcase

        // Main outputs are reclocked to the main clock.
        s_next.mout = dly_out[NCH-1:0];
        // The logic channel only moves on a logic clock edge.
        if (lclk_rise) begin
            s_next.lout = dly_out[NCH];
        end
    end

    // State register with documented reset values.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.post <= RST_POST;
            s_reg.per <= RST_PER;
        end else begin
            s_reg <= s_next;
        end
    end

    // Logic clock divider.
    assign lcfg = '{pre: s_reg.pre, post: s_reg.post};
    lcsr_lcdiv u_lcdiv (
        .clk(clk),
        .rst_b(rst_b),
        .cfg(lcfg),
        .sync(sync_ev),
        .lclk(lclk),
        .rise(lclk_rise)
    );

    // One delay line per output; the shared source feeds all of them.
    generate
        for (genvar i = 0; i <= NCH; i++) begin : g_dly
            lcsr_delay #(
                .DEPTH(DDEPTH)
            ) u_dly (
                .clk(clk),
                .rst_b(rst_b),
                .din(s_reg.src),
                .sel(s_reg.dly[DLY_W*i +: DLY_W]),
                .bypass(s_reg.path == PATH_BYPASS),
                .dout(dly_out[i])
            );
        end
        // Output buffer settings, common mode low, level high.
        for (genvar j = 0; j < NCH; j++) begin : g_ocfg
            assign frame_ref_out_common_mode[VCM_W*j +: VCM_W] = s_reg.ocfg[2*VCM_W*j +: VCM_W];
            assign frame_ref_out_level[VCM_W*j +: VCM_W] = s_reg.ocfg[2*VCM_W*j+VCM_W +: VCM_W];
        end
    endgenerate

    // Zero wait states keep the slave simple.
    assign pready = 1'h1;
    assign pslverr = s_reg.err;
    assign prdata = s_reg.rdata;
    assign logic_clock_output = lclk;
    assign frame_ref_main_outputs = s_reg.mout;
    assign frame_ref_logic_output = s_reg.lout;

    // Checks run on the block clock and stop under reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Prescale by two with bypass toggles each cycle.
    a_pre_div_two: assert property (
        (s_reg.pre == 2'h1 && s_reg.post == 10'h001 && !sync_ev)[*3] |-> lclk != $past(lclk)
    ) else $error("prescaler by two does not toggle");

    // Ratio three repeats every three cycles.
    a_post_period: assert property (
        (lclk_rise && s_reg.pre == 2'h0 && s_reg.post == 10'h003 && !sync_ev)
        ##1 (s_reg.pre == 2'h0 && s_reg.post == 10'h003 && !sync_ev)[*2] |=> lclk_rise
    ) else $error("post divider period wrong");

    // Ratio three is high one cycle, even ratio four is high two.
    a_duty_odd: assert property (
        (s_reg.pre == 2'h0 && (s_reg.post == 10'h003 || s_reg.post == 10'h004) && !sync_ev)[*2]
        ##0 $rose(lclk) |=> lclk == (s_reg.post == 10'h004)
    ) else $error("logic clock duty wrong");

    // Sync puts the divider at phase zero, which is high.
    a_sync_phase: assert property (
        sync_ev && s_reg.post > 10'h001 |=> lclk
    ) else $error("sync did not reset divider phase");

    // Logic channel reference changes only after a logic clock edge.
    a_logic_reclk: assert property (
        frame_ref_logic_output != $past(frame_ref_logic_output) |-> $past(lclk_rise)
    ) else $error("logic reference not reclocked");

    // Tap two gives five cycles from source to main output.
    a_delay_tap: assert property (
        (s_reg.dly[DLY_W-1:0] == 4'h2 && s_reg.path != PATH_BYPASS)[*6]
        |-> frame_ref_main_outputs[0] == $past(s_reg.src, 5)
    ) else $error("delay tap timing wrong");

    // Continuous period four alternates every two cycles.
    a_cont_stream: assert property (
        (s_reg.mode == MODE_CONT && gate && s_reg.per == 8'h04 && !sync_ev)[*5]
        |-> s_reg.src != $past(s_reg.src, 2)
    ) else $error("continuous stream broken");

    // No request means no output in continuous mode.
    a_cont_gate: assert property (
        s_reg.mode == MODE_CONT && !gate |=> !s_reg.src
    ) else $error("ungated continuous output");

    // A burst loads its full count.
    a_burst_load: assert property (
        start && !sync_ev |=> s_reg.active && s_reg.left == $past(s_reg.len) + 5'h01
    ) else $error("burst count not loaded");

    // A burst starts at phase zero on a pin edge.
    a_burst_start: assert property (
        s_reg.mode == MODE_PULSER && req_rise && !sync_ev |=> s_reg.gcnt == 8'h00 && s_reg.active
    ) else $error("burst did not start on edge");

    // Repeater output is the pin two cycles late.
    a_repeat_path: assert property (
        (s_reg.mode == MODE_REPEAT)[*2] |-> s_reg.src == $past(frame_ref_request_pins, 2)
    ) else $error("repeater path wrong");

    // Output settings follow a write.
    a_out_cfg: assert property (
        psel && penable && pwrite && paddr == LCSR_OFF_FOUT
        |=> frame_ref_out_level[2:0] == $past(pwdata[5:3]) && frame_ref_out_common_mode[2:0] == $past(pwdata[2:0])
    ) else $error("output settings not applied");

    // Reserved mode stays silent.
    a_rsvd_quiet: assert property (
        (s_reg.mode == MODE_RSVD)[*2] |-> !s_reg.src
    ) else $error("reserved mode produced output");

    // Main scenarios.
    c_burst: cover property (start ##1 s_reg.active);
    c_cont: cover property (s_reg.mode == MODE_CONT && $rose(s_reg.src));
    c_repeat: cover property (s_reg.mode == MODE_REPEAT && $rose(frame_ref_main_outputs[0]));
    c_sync: cover property (sync_ev ##1 lclk_rise);
endmodule : lcsr_top
`default_nettype wire

// >>> tb/lcsr_req_model.sv
// Model of the far-side party that drives the frame reference request pins.
`timescale 1ns/100ps
`default_nettype none
module lcsr_req_model (
    input wire logic clk, // Block clock.
    output var logic pin // Request pin level seen by the block.
);
    // The pin rests low so software requests are not disturbed.
    initial pin = 1'b0;
    // Changes the pin level just after a clock edge.
    task automatic set_level(input logic v);
        @(posedge clk);
        pin <= v;
    endtask : set_level
    // Raises the pin for n cycles, then holds it low again.
    task automatic pulse(input int n);
        set_level(1'b1);
        repeat (n) @(posedge clk);
        pin <= 1'b0;
    endtask : pulse
endmodule : lcsr_req_model
`default_nettype wire

// >>> tb/lcsr_tb_top.sv
// Self-checking bench for the logic clock and frame reference block.
`timescale 1ns/100ps
`default_nettype none
module lcsr_tb_top;
    import lcsr_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, req, sync_pin, lclk, lref;
    logic [11:0] paddr, ua;
    logic [31:0] pwdata, prdata, v, ec, el;
    logic [3:0] main_o;
    logic [11:0] cm_o, lv_o;
    logic [32:0] exp_q[$]; // Expected read answers, oldest first.
    int err_total, tests_run, n0, n3, nl, hi, per, a, b;
    int lens[3];
    lcsr_top #(.NCH(4)) lcsr_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_ref_request_pins(req), .sync_pin(sync_pin),
        .logic_clock_output(lclk), .frame_ref_main_outputs(main_o), .frame_ref_logic_output(lref),
        .frame_ref_out_common_mode(cm_o), .frame_ref_out_level(lv_o));
    lcsr_req_model lcsr_req_model_inst (.clk(clk), .pin(req));
    // Compares one value and counts the outcome.
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // One APB transfer; a read notes its expected error flag and data first.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        if (!wr) exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Counts rising edges on the first and last main outputs and the logic channel over a window.
    task automatic count(input int cyc);
        logic [4:0] p;
        p = {lref, main_o};
        n0 = 0;
        n3 = 0;
        nl = 0;
        repeat (cyc) begin
            @(posedge clk);
            n0 += int'(main_o[0] && !p[0]);
            n3 += int'(main_o[3] && !p[3]);
            nl += int'(lref && !p[4]);
            p = {lref, main_o};
        end
    endtask : count
    // Measures high time and period of the logic clock in cycles.
    task automatic lc_meas();
        while (lclk !== 1'b0) @(posedge clk);
        while (lclk !== 1'b1) @(posedge clk);
        hi = 0;
        per = 0;
        while (lclk === 1'b1) begin @(posedge clk); hi++; end
        per = hi;
        while (lclk === 1'b0) begin @(posedge clk); per++; end
    endtask : lc_meas
    // Cycles from a request pin rise to the first main output rise.
    task automatic lat(output int c);
        lcsr_req_model_inst.set_level(1'b1);
        c = 0;
        while (main_o[0] !== 1'b1) begin @(posedge clk); c++; end
        lcsr_req_model_inst.set_level(1'b0);
        repeat (30) @(posedge clk);
    endtask : lat
    // Free-running block clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Read answers are compared against the oldest note when the access phase completes.
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
    end
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #4000000;
        err_total++;
        complete_run();
    end
    // Main sequence of scenarios.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sync_pin, err_total, tests_run} = '0;
        rst_b = 1'b0;
        void'($urandom(497));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, LCSR_OFF_LDIV, 0, {1'b0, 32'h1});
        apb(0, LCSR_OFF_FCFG, 0, {1'b0, 32'h1000});
        // Any unmapped word answers with an error and reads as zero.
        ua = 12'h018 + 12'(($urandom % 32) * 4);
        apb(1, ua, 32'hFF, '0);
        apb(0, ua, 0, {1'b1, 32'h0});
        v = $urandom & 32'hFFFFFF;
        apb(1, LCSR_OFF_FOUT, v, '0);
        apb(0, LCSR_OFF_FOUT, 0, {1'b0, v});
        for (int i = 0; i < 4; i++) begin
            ec[3*i+:3] = v[6*i+:3];
            el[3*i+:3] = v[6*i+3+:3];
        end
        chk(cm_o, ec[11:0]);
        chk(lv_o, el[11:0]);
        // Prescaler code, post ratio, expected high time and period; odd passes sync by the command bit.
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 1 : (i == 1) ? 0 : (i == 2) ? 2 : 1;
            b = (i == 0) ? 4 : (i == 1) ? 3 : (i == 2) ? 5 : 1;
            apb(1, LCSR_OFF_LDIV, b, '0);
            apb(1, LCSR_OFF_CTRL, (a << 4) | ((i % 2) << 3), '0);
            if (i % 2 == 0) begin
                sync_pin <= 1'b1;
                @(posedge clk) sync_pin <= 1'b0;
            end
            lc_meas();
            chk(hi, (i == 0) ? 4 : (i == 1) ? 1 : (i == 2) ? 8 : 1);
            chk(per, (i == 0) ? 8 : (i == 1) ? 3 : (i == 2) ? 20 : 2);
        end
        lens = '{1, 16, ($urandom % 16) + 1};
        foreach (lens[i]) begin
            apb(1, LCSR_OFF_FCFG, 32'h410 | (lens[i] - 1), '0);
            apb(1, LCSR_OFF_CTRL, 32'h1, '0);
            fork
                lcsr_req_model_inst.pulse(2);
                count(lens[i] * 4 + 30);
            join
            chk(n0, lens[i]);
            chk(n3, n0);
            chk(nl, lens[i]);
            apb(1, LCSR_OFF_CTRL, 32'h5, '0);
            count(lens[i] * 4 + 30);
            chk(n0, lens[i]);
        end
        apb(1, LCSR_OFF_CTRL, 32'h0, '0);
        count(40);
        chk(n0, 0);
        apb(1, LCSR_OFF_CTRL, 32'h4, '0);
        count(40);
        chk(n0 >= 9 && n0 <= 11, 1);
        lcsr_req_model_inst.set_level(1'b1);
        apb(1, LCSR_OFF_CTRL, 32'h3, '0);
        repeat (10) @(posedge clk);
        count(40);
        chk(n0, 0);
        lcsr_req_model_inst.set_level(1'b0);
        apb(1, LCSR_OFF_CTRL, 32'h2, '0);
        repeat (10) @(posedge clk);
        // Two reclock stages, two through the bypass path, and one because the level is read before the edge.
        lat(a);
        chk(a, 5);
        per = $urandom % 16;
        apb(1, LCSR_OFF_FCFG, 32'h400, '0);
        apb(1, LCSR_OFF_FDLY, per, '0);
        lat(b);
        // The tap path costs one stage more than the bypass, plus one cycle per tap.
        chk(b, per + 6);
        complete_run();
    end
endmodule : lcsr_tb_top
`default_nettype wire
